// ### design/fuse_prom_ctrl.v
// Host controller that reads and programs a 2048x8 fuse PROM through its pins
`timescale 1ns/1ps
`include "fuse_prom_map.vh"
module fuse_prom_ctrl #(
  parameter AW = 11,
  parameter DW = 8,
  parameter MAX_PULSES = 32,
  parameter CONFIRM_CYC = `FP_CONFIRM_CYC,
  parameter ADDR_GAP_CYC = `FP_ADDR_GAP_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // User command port
  input wire req_valid_i,
  input wire req_prog_i,
  input wire [AW-1:0] req_addr_i,
  input wire [DW-1:0] req_data_i,
  output wire req_ready_o,
  output reg done_o,
  output reg fail_o,
  output reg [DW-1:0] rd_data_o,
  // PROM pins
  output reg [AW-1:0] word_select_lines_o,
  output reg enable_low_active_o,
  output reg enable_high_active_a_o,
  output reg enable_high_active_b_o,
  input wire [DW-1:0] word_output_lines_i,
  // Programming equipment drive per output line
  output reg [DW-1:0] sense_en_o,
  output reg [DW-1:0] pulse_en_o,
  input wire [DW-1:0] sense_pass_i
);
  // States
  localparam S_IDLE = 4'h0;
  localparam S_GAP1 = 4'h1;
  localparam S_READ = 4'h2;
  localparam S_SEL = 4'h3;
  localparam S_SENSE1 = 4'h4;
  localparam S_PULSE = 4'h5;
  localparam S_SDLY = 4'h6;
  localparam S_CONF = 4'h7;
  localparam S_EXTRA = 4'h8;
  localparam S_XDLY = 4'h9;
  localparam S_GAP2 = 4'ha;
  localparam S_VERIFY = 4'hb;
  localparam S_DONE = 4'hc;
  localparam S_SETTLE = 4'hd;

  reg [3:0] st_q;          // Current state
  reg [15:0] cnt_q;        // Timer
  reg [7:0] npulse_q;      // Pulses on current bit
  reg [2:0] bit_q;         // Bit being programmed
  reg [2:0] extra_q;       // Extra pulses given
  reg prog_q;              // Command is a program
  reg [DW-1:0] data_q;     // Target pattern
  reg [DW-1:0] onehot;     // Selected bit as a mask
  wire [3:0] nxt_bit;      // Next set bit at or above bit_q, 8 when none

  // Ready only when idle
  assign req_ready_o = (st_q == S_IDLE);

  // Next bit to program, from bit index upward; 8 with none left handled by check
  function [3:0] next_bit;
    input [DW-1:0] pat;
    input [3:0] from;
    integer k;
    begin
      next_bit = 4'h8;
      for (k = DW - 1; k >= 0; k = k - 1) begin
        if (pat[k] && (k >= from)) begin
          next_bit = k[3:0];
        end
      end
    end
  endfunction

  // Decoded bit mask
  always @* begin
    onehot = {{(DW-1){1'b0}}, 1'b1} << bit_q;
  end

  // Search result held on a net so the sequencer can slice it
  assign nxt_bit = next_bit(data_q, {1'b0, bit_q});

  // Main sequencer
  always @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= S_IDLE;
      cnt_q <= 16'h0000;
      npulse_q <= 8'h00;
      bit_q <= 3'h0;
      extra_q <= 3'h0;
      prog_q <= 1'b0;
      data_q <= 8'h00;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      rd_data_o <= 8'h00;
      word_select_lines_o <= 11'h000;
      enable_low_active_o <= 1'b1;   // Disabled at reset
      enable_high_active_a_o <= 1'b0;
      enable_high_active_b_o <= 1'b0;
      sense_en_o <= 8'h00;
      pulse_en_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      case (st_q)
        // Take a command; sense is off here
        S_IDLE: begin
          if (req_valid_i) begin
            prog_q <= req_prog_i;
            data_q <= req_data_i;
            fail_o <= 1'b0;
            cnt_q <= 16'h0000;
            st_q <= S_GAP1;
          end
        end
        // Sense current off for the gap before the address moves
        S_GAP1: begin
          if (cnt_q >= ADDR_GAP_CYC[15:0]) begin
            word_select_lines_o <= req_addr_i; // One address path
            cnt_q <= 16'h0000;
            st_q <= prog_q ? S_SETTLE : S_READ; // Program waits again before sensing
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        // Sense stays off for the gap after the address moved
        S_SETTLE: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q >= ADDR_GAP_CYC[15:0]) begin
            cnt_q <= 16'h0000;
            st_q <= S_SEL;
          end
        end
        // Normal read with enables active
        S_READ: begin
          enable_low_active_o <= 1'b0;
          enable_high_active_a_o <= 1'b1;
          enable_high_active_b_o <= 1'b1;
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'h0002) begin
            rd_data_o <= word_output_lines_i;
            cnt_q <= 16'h0000;
            st_q <= S_DONE;
          end
        end
        // Pick the next bit to burn, one at a time
        S_SEL: begin
          enable_low_active_o <= 1'b1;   // Outputs off before pulsing
          enable_high_active_a_o <= 1'b0;
          enable_high_active_b_o <= 1'b0;
          sense_en_o <= 8'h00;
          if (nxt_bit == 4'h8) begin
            cnt_q <= 16'h0000;
            st_q <= S_GAP2;
          end else begin
            bit_q <= nxt_bit[2:0];
            npulse_q <= 8'h00;
            extra_q <= 3'h0;
            cnt_q <= 16'h0000;
            st_q <= S_SENSE1;
          end
        end
        // Sense first; a pass starts the confirm interval
        S_SENSE1: begin
          sense_en_o <= onehot;
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'h0001) begin
            cnt_q <= 16'h0000;
            if (sense_pass_i[bit_q]) begin
              st_q <= S_CONF;
            end else if (npulse_q >= MAX_PULSES[7:0]) begin
              fail_o <= 1'b1;          // Bit would not blow
              sense_en_o <= 8'h00;
              st_q <= S_GAP2;
            end else begin
              st_q <= S_PULSE;
            end
          end
        end
        // Programming pulse of fixed width, chip still disabled
        S_PULSE: begin
          pulse_en_o <= onehot;
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `FP_PULSE_CYC - 1) begin
            pulse_en_o <= 8'h00;
            npulse_q <= npulse_q + 8'h01;
            cnt_q <= 16'h0000;
            st_q <= S_SDLY;
          end
        end
        // Wait after trailing edge before sensing
        S_SDLY: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `FP_SENSE_DLY_CYC - 1) begin
            cnt_q <= 16'h0000;
            st_q <= S_SENSE1;
          end
        end
        // Second sense a full interval later, no pulse between
        S_CONF: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == CONFIRM_CYC[15:0]) begin
            cnt_q <= 16'h0000;
            st_q <= sense_pass_i[bit_q] ? S_EXTRA : S_PULSE;
          end
        end
        // Four further pulses after the bit is judged
        S_EXTRA: begin
          pulse_en_o <= onehot;
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `FP_PULSE_CYC - 1) begin
            pulse_en_o <= 8'h00;
            extra_q <= extra_q + 3'h1;
            cnt_q <= 16'h0000;
            st_q <= S_XDLY;
          end
        end
        // Gap between extras, then drop sense current
        S_XDLY: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `FP_SENSE_DLY_CYC - 1) begin
            cnt_q <= 16'h0000;
            if (extra_q == `FP_EXTRA_PULSES) begin
              sense_en_o <= 8'h00;
              npulse_q <= 8'h01;
              if (bit_q == 3'h7) begin
                st_q <= S_GAP2;
              end else begin
                bit_q <= bit_q + 3'h1;
                st_q <= S_SEL;
              end
            end else begin
              st_q <= S_EXTRA;
            end
          end
        end
        // Sense off before verify read
        S_GAP2: begin
          sense_en_o <= 8'h00;
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q >= ADDR_GAP_CYC[15:0]) begin
            cnt_q <= 16'h0000;
            st_q <= S_VERIFY;
          end
        end
        // Normal read and compare with the pattern
        S_VERIFY: begin
          enable_low_active_o <= 1'b0;
          enable_high_active_a_o <= 1'b1;
          enable_high_active_b_o <= 1'b1;
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'h0002) begin
            rd_data_o <= word_output_lines_i;
            if (word_output_lines_i != data_q) begin
              fail_o <= 1'b1;
            end
            st_q <= S_DONE;
          end
        end
        // Finish: disable, pulse done
        S_DONE: begin
          enable_low_active_o <= 1'b1;
          enable_high_active_a_o <= 1'b0;
          enable_high_active_b_o <= 1'b0;
          bit_q <= 3'h0;
          npulse_q <= 8'h00;
          cnt_q <= 16'h0000;
          done_o <= 1'b1;
          st_q <= S_IDLE;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // fuse_prom_ctrl

// ### pkg/fuse_prom_map.vh
// Constants for the fuse PROM read and program controller
`ifndef FUSE_PROM_MAP_VH
`define FUSE_PROM_MAP_VH
// Clock period in ns
`define FP_CLK_NS 10
// Programming pulse width in ns (7.5 us)
`define FP_PULSE_NS 7500
// Least delay from pulse trailing edge to sense, ns (0.7 us)
`define FP_SENSE_DLY_NS 700
// Spacing of the two confirming sense readings, ns (10 us)
`define FP_CONFIRM_NS 10000
// Sense current interruption around address change, ns (10 us)
`define FP_ADDR_GAP_NS 10000
// Derived cycle counts
`define FP_PULSE_CYC (`FP_PULSE_NS / `FP_CLK_NS)
`define FP_SENSE_DLY_CYC ((`FP_SENSE_DLY_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_CONFIRM_CYC ((`FP_CONFIRM_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_ADDR_GAP_CYC ((`FP_ADDR_GAP_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
// Extra pulses after a bit is judged programmed
`define FP_EXTRA_PULSES 4
`endif

// ### dv/fuse_prom_monitor.sv
// Pin timing checker for the fuse PROM controller
`timescale 1ns/1ps
`include "fuse_prom_map.vh"
module fuse_prom_monitor #(
  parameter ADDR_GAP_CYC = 1000
) (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Observed outputs
  input wire done_o,
  input wire [10:0] word_select_lines_o,
  input wire enable_low_active_o,
  input wire enable_high_active_a_o,
  input wire enable_high_active_b_o,
  input wire [7:0] sense_en_o,
  input wire [7:0] pulse_en_o
);
  // Chip enabled and any pulse active
  wire on = !enable_low_active_o && enable_high_active_a_o && enable_high_active_b_o;
  wire pz = |pulse_en_o;
  // Sense off run, since address change, pulse length, pulse idle
  reg [15:0] off_q, chg_q, len_q, idl_q;
  // Counters, saturating except len_q
  always @(posedge clk_i) begin
    if (srst_i) begin
      off_q <= 16'h0;
      chg_q <= 16'h0;
      len_q <= 16'h0;
      idl_q <= 16'hffff;
    end else begin
      off_q <= (|sense_en_o) ? 16'h0 : off_q + {15'h0, ~&off_q};
      chg_q <= $changed(word_select_lines_o) ? 16'h0 : chg_q + {15'h0, ~&chg_q};
      len_q <= pz ? len_q + 16'h1 : 16'h0;
      idl_q <= pz ? 16'h0 : idl_q + {15'h0, ~&idl_q};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  a_pulse_chip_off: assert property (pz |-> !on)
    else $error("pulse while enabled");
  a_one_line: assert property ($onehot0(pulse_en_o))
    else $error("several lines pulsed");
  // len_q counts every high cycle; the controller pulse lasts FP_PULSE_CYC - 1 cycles
  a_pulse_width: assert property ($fell(pz) |-> len_q == `FP_PULSE_CYC - 1)
    else $error("bad pulse width");
  a_sense_delay: assert property ($rose(pz) |-> idl_q >= `FP_SENSE_DLY_CYC)
    else $error("pulse gap short");
  a_gap_before: assert property ($changed(word_select_lines_o) |-> off_q >= ADDR_GAP_CYC - 1)
    else $error("sense on before address change");
  a_gap_after: assert property ((|sense_en_o) |-> chg_q >= ADDR_GAP_CYC - 1)
    else $error("sense soon after address change");
  a_done_single: assert property (done_o |=> !done_o)
    else $error("done too long");
  a_read_window: assert property ($rose(on) |-> on[*3] ##1 !on)
    else $error("bad read window");
  c_pulse: cover property ($rose(pz));
  c_read: cover property ($rose(on));
  c_done: cover property (done_o);
endmodule // fuse_prom_monitor
bind fuse_prom_ctrl fuse_prom_monitor #(.ADDR_GAP_CYC(ADDR_GAP_CYC)) fuse_prom_monitor_inst (
  .clk_i(clk_i), .srst_i(srst_i), .done_o(done_o), .word_select_lines_o(word_select_lines_o),
  .enable_low_active_o(enable_low_active_o), .enable_high_active_a_o(enable_high_active_a_o),
  .enable_high_active_b_o(enable_high_active_b_o), .sense_en_o(sense_en_o),
  .pulse_en_o(pulse_en_o));

// ### dv/fuse_prom_model.sv
// Behavioural 2048x8 fuse PROM with per-line sense comparators
`timescale 1ns/1ps
module fuse_prom_model #(
  parameter BLOW = 2
) (
  // Clock and pins
  input wire clk_i,
  input wire [10:0] word_select_lines_i,
  input wire enable_low_active_i,
  input wire enable_high_active_a_i,
  input wire enable_high_active_b_i,
  input wire [7:0] pulse_en_i,
  input wire [7:0] sense_en_i,
  // Lines whose fuse never opens
  input wire [7:0] stuck_i,
  // Outputs
  output wire [7:0] word_output_lines_o,
  output wire [7:0] sense_pass_o
);
  reg [7:0] mem_q [0:2047];
  reg [3:0] hit_q [0:16383];
  reg [7:0] prv_q;
  reg flt_q;
  integer i;
  wire on = !enable_low_active_i && enable_high_active_a_i && enable_high_active_b_i;
  // All fuses blank at power up
  initial begin
    for (i = 0; i < 16384; i = i + 1) hit_q[i] = 4'h0;
    for (i = 0; i < 2048; i = i + 1) mem_q[i] = 8'h00;
    prv_q = 8'h00;
    flt_q = 1'b0;
  end
  // Pulses on a disabled chip wear the addressed fuse open
  always @(posedge clk_i) begin
    prv_q <= pulse_en_i;
    flt_q <= ~flt_q;
    for (i = 0; i < 8; i = i + 1) begin
      if (pulse_en_i[i] && !prv_q[i] && !on && !stuck_i[i]) begin
        hit_q[{word_select_lines_i, i[2:0]}] <= hit_q[{word_select_lines_i, i[2:0]}] + 4'h1;
        if (hit_q[{word_select_lines_i, i[2:0]}] + 4'h1 >= BLOW) begin
          mem_q[word_select_lines_i][i] <= 1'b1;
        end
      end
    end
  end
  // Floating outputs toggle so no stale value survives
  assign word_output_lines_o = on ? mem_q[word_select_lines_i] : {8{flt_q}};
  assign sense_pass_o = sense_en_i & mem_q[word_select_lines_i];
endmodule // fuse_prom_model

// ### dv/tb_fuse_prom_ctrl.sv
// Self-checking bench for the fuse PROM controller
`timescale 1ns/1ps
module tb_fuse_prom_ctrl;
  localparam GAP = 20;
  localparam BLOW = 2;
  // Inputs
  reg clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg req_valid_i = 1'b0;
  reg req_prog_i = 1'b0;
  reg [10:0] req_addr_i = 11'h000;
  reg [7:0] req_data_i = 8'h00;
  reg [7:0] stuck = 8'h00;
  // Outputs and pins
  wire req_ready_o, done_o, fail_o, en_lo, en_a, en_b;
  wire [7:0] rd_data_o, wout, sen, pen, spass;
  wire [10:0] apin;
  reg [7:0] prv = 8'h00;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer pulses [0:7];
  integer k;
  initial forever #5 clk_i = ~clk_i;
  fuse_prom_ctrl #(.CONFIRM_CYC(GAP), .ADDR_GAP_CYC(GAP)) fuse_prom_ctrl_inst (
    .clk_i(clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i), .req_prog_i(req_prog_i),
    .req_addr_i(req_addr_i), .req_data_i(req_data_i), .req_ready_o(req_ready_o),
    .done_o(done_o), .fail_o(fail_o), .rd_data_o(rd_data_o), .word_select_lines_o(apin),
    .enable_low_active_o(en_lo), .enable_high_active_a_o(en_a), .enable_high_active_b_o(en_b),
    .word_output_lines_i(wout), .sense_en_o(sen), .pulse_en_o(pen), .sense_pass_i(spass));
  fuse_prom_model #(.BLOW(BLOW)) fuse_prom_model_inst (
    .clk_i(clk_i), .word_select_lines_i(apin), .enable_low_active_i(en_lo),
    .enable_high_active_a_i(en_a), .enable_high_active_b_i(en_b), .pulse_en_i(pen),
    .sense_en_i(sen), .stuck_i(stuck), .word_output_lines_o(wout), .sense_pass_o(spass));
  // Count pulse starts per line
  always @(posedge clk_i) begin
    prv <= pen;
    for (k = 0; k < 8; k = k + 1) if (pen[k] && !prv[k]) pulses[k] = pulses[k] + 1;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // One command, waited for under a bound
  task run(input p, input [10:0] a, input [7:0] d, input [7:0] ex, input f);
    integer n;
    begin
      for (n = 0; n < 8; n = n + 1) pulses[n] = 0;
      @(posedge clk_i);
      #1 {req_valid_i, req_prog_i, req_addr_i, req_data_i} = {1'b1, p, a, d};
      @(posedge clk_i);
      #1 req_valid_i = 1'b0;
      for (n = 0; n < 40000 && done_o !== 1'b1; n = n + 1) @(posedge clk_i) #1;
      check(done_o, 1'b1);
      check(fail_o, f);
      if (!f) check(rd_data_o, ex);
    end
  endtask
  task t_idle;
    begin
      check({req_ready_o, en_lo, en_a, en_b, sen, pen}, 20'hc0000);
    end
  endtask
  task t_blank;
    begin
      run(0, 11'h000, 8'hff, 8'h00, 0);
      run(0, 11'h7ff, 8'hff, 8'h00, 0);
    end
  endtask
  task t_prog;
    begin
      run(1, 11'h123, 8'ha5, 8'ha5, 0);
      for (k = 0; k < 8; k = k + 1) check(pulses[k], (8'ha5 >> k) & 1 ? BLOW + 4 : 0);
      run(1, 11'h7ff, 8'h80, 8'h80, 0);
      check(pulses[7], BLOW + 4);
      run(0, 11'h123, 8'h00, 8'ha5, 0);
      run(0, 11'h124, 8'h00, 8'h00, 0);
    end
  endtask
  task t_fail;
    begin
      stuck = 8'h01;
      run(1, 11'h010, 8'h03, 8'h00, 1);
      check(pulses[1], 0);
      check(pulses[0], 32);
      stuck = 8'h00;
      run(0, 11'h010, 8'h00, 8'h00, 0);
    end
  endtask
  task end_of_test;
    begin
      if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #900000;
    n_errors = n_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    #1 srst_i = 1'b0;
    t_idle;
    t_blank;
    t_prog;
    t_fail;
    end_of_test;
  end
endmodule // tb_fuse_prom_ctrl
